// >>> pwx_defs.svh
// Constants for the primary bus wide extension ends
// Notes on behaviour
// RULE1: Dual address: upper address on upper lanes
// RULE2: Otherwise upper lanes held at valid levels
// RULE3: Wide data phase: supplier drives upper data
// RULE4: Dual address: command on upper command lanes
// RULE5: Wide data phase: initiator drives upper enables
// RULE6: Upper parity is even over 36 bits
// RULE7: Parity valid one cycle after address phases
// RULE8: Data supplier drives parity one cycle later
// RULE9: Wide request follows frame timing exactly
// RULE10: Strap low at reset enables wide path
// RULE11: Strap high: park upper lanes permanently driven
// RULE12: Acknowledge only with request, like devsel
// RULE13: Drive released line high one cycle first
// RULE14: Dual address command first, then real command
// RULE15: No acknowledge: lower lanes only, upper ignored
`ifndef PWX_DEFS_SVH
`define PWX_DEFS_SVH
`define PWX_CMD_DAC    4'hD
`define PWX_CMD_MEMRD  4'h6
`define PWX_CMD_MEMWR  4'h7
`define PWX_ABORT_CYC  3'h5
`define PWX_PULL32     32'hFFFFFFFF
`define PWX_PULL4      4'hF
`define PWX_ZERO32     32'h00000000
`endif

// >>> pwx_pkg.sv
// Types shared by both ends of the wide extension
package pwx_pkg;
  // Initiator sequencing
  typedef enum logic [2:0] {
    pwx_i_idle, pwx_i_addr1, pwx_i_addr2, pwx_i_data, pwx_i_done
  } pwx_ini_state_t;
  // Target sequencing
  typedef enum logic [2:0] {
    pwx_t_idle, pwx_t_addr2, pwx_t_claim, pwx_t_data, pwx_t_rel
  } pwx_tgt_state_t;
endpackage : pwx_pkg

// >>> pwx_if.sv
// Shared primary bus wires with pull-up resolution
`timescale 1ns/100ps
`include "pwx_defs.svh"
interface pwx_if;
  logic [63:0] i_ad;            // Initiator address/data drive
  logic        i_ad_oe_lo;      // Initiator lower lane enable
  logic        i_ad_oe_hi;      // Initiator upper lane enable
  logic [7:0]  i_cbe;           // Initiator command/enables
  logic        i_cbe_oe_lo;
  logic        i_cbe_oe_hi;
  logic        i_par64;
  logic        i_par64_oe;
  logic        i_frame_n;
  logic        i_frame_oe;
  logic        i_irdy_n;
  logic        i_irdy_oe;
  logic        i_req64_n;
  logic        i_req64_oe;
  logic [63:0] t_ad;            // Target read data drive
  logic        t_ad_oe_lo;
  logic        t_ad_oe_hi;
  logic        t_par64;
  logic        t_par64_oe;
  logic        t_devsel_n;
  logic        t_devsel_oe;
  logic        t_trdy_n;
  logic        t_trdy_oe;
  logic        t_ack64_n;
  logic        t_ack64_oe;
  logic        board_req64_n;   // Board level on the request line, set by the bench
  // Resolved wire levels; undriven lines float to the pull-up, except the wide request line, which takes the board level
  logic [63:0] ad;
  logic [7:0]  cbe;
  logic        primary_upper_parity;
  logic        frame_n;
  logic        irdy_n;
  logic        devsel_n;
  logic        trdy_n;
  logic        primary_wide_request_n;
  logic        primary_wide_ack_n;
  assign ad[31:0]  = i_ad_oe_lo ? i_ad[31:0]  : t_ad_oe_lo ? t_ad[31:0]  : `PWX_PULL32;
  assign ad[63:32] = i_ad_oe_hi ? i_ad[63:32] : t_ad_oe_hi ? t_ad[63:32] : `PWX_PULL32;
  assign cbe[3:0]  = i_cbe_oe_lo ? i_cbe[3:0] : `PWX_PULL4;
  assign cbe[7:4]  = i_cbe_oe_hi ? i_cbe[7:4] : `PWX_PULL4;
  assign primary_upper_parity = i_par64_oe ? i_par64 : t_par64_oe ? t_par64 : 1'b1;
  assign frame_n  = i_frame_oe ? i_frame_n : 1'b1;
  assign irdy_n   = i_irdy_oe ? i_irdy_n : 1'b1;
  assign devsel_n = t_devsel_oe ? t_devsel_n : 1'b1;
  assign trdy_n   = t_trdy_oe ? t_trdy_n : 1'b1;
  assign primary_wide_request_n = i_req64_oe ? i_req64_n : board_req64_n;
  assign primary_wide_ack_n     = t_ack64_oe ? t_ack64_n : 1'b1;
  modport init (
    output i_ad, i_ad_oe_lo, i_ad_oe_hi, i_cbe, i_cbe_oe_lo, i_cbe_oe_hi,
    output i_par64, i_par64_oe, i_frame_n, i_frame_oe, i_irdy_n, i_irdy_oe,
    output i_req64_n, i_req64_oe,
    input  ad, cbe, primary_upper_parity, frame_n, irdy_n, devsel_n, trdy_n,
    input  primary_wide_request_n, primary_wide_ack_n
  );
  modport tgt (
    output t_ad, t_ad_oe_lo, t_ad_oe_hi, t_par64, t_par64_oe,
    output t_devsel_n, t_devsel_oe, t_trdy_n, t_trdy_oe, t_ack64_n, t_ack64_oe,
    input  ad, cbe, primary_upper_parity, frame_n, irdy_n, devsel_n, trdy_n,
    input  primary_wide_request_n, primary_wide_ack_n
  );
endinterface : pwx_if

// >>> pwx_target.sv
// Far-end target agent with a small word store
`timescale 1ns/100ps
`include "pwx_defs.svh"
module pwx_target
  import pwx_pkg::*;
#(
  parameter int WORDS = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  pwx_if.tgt               bus,
  input  wire logic        wide_en,
  output logic             wr_strobe,
  output logic [63:0]      wr_data,
  output logic [7:0]       wr_be,
  output logic             wide_seen
);
  localparam int IW = (WORDS > 1) ? $clog2(WORDS) : 1;

  pwx_tgt_state_t st;            // Target sequence
  logic [63:0]    store [WORDS]; // Word store, no reset needed
  logic [31:0]    addr_lo;       // Lower address of the access
  logic [3:0]     cmd;           // Transaction command
  logic           req_seen;      // Wide request seen at address time
  logic           acked;         // Wide acknowledge given
  logic [IW-1:0]  idx;
  logic [7:0]     be_ok;         // Active byte lanes this phase
  logic           is_wr;

  assign idx   = addr_lo[IW+2:3];
  assign is_wr = cmd[0];
  // RULE15: narrow lanes only
  assign be_ok = ~bus.cbe & {{4{acked}}, 4'hF};

  // Sequence and address capture
  always_ff @(posedge clk) begin
    if (rst) begin
      st       <= pwx_t_idle;
      addr_lo  <= `PWX_ZERO32;
      cmd      <= `PWX_CMD_MEMRD;
      req_seen <= 1'b0;
    end else begin
      case (st)
        pwx_t_idle: begin
          if (!bus.frame_n) begin
            addr_lo  <= bus.ad[31:0];
            cmd      <= bus.cbe[3:0];
            req_seen <= !bus.primary_wide_request_n;
            // RULE14: dual address decode
            st <= (bus.cbe[3:0] == `PWX_CMD_DAC) ? pwx_t_addr2 : pwx_t_claim;
          end
        end
        // Second phase carries the real command
        pwx_t_addr2: begin
          cmd <= bus.cbe[3:0];
          st  <= pwx_t_claim;
        end
        pwx_t_claim: st <= pwx_t_data;
        // Leave only when both ready lines meet, or write capture is missed
        pwx_t_data:  if (!bus.irdy_n && !bus.trdy_n) st <= pwx_t_rel;
        pwx_t_rel:   st <= pwx_t_idle;
        default:     st <= pwx_t_idle;
      endcase
    end
  end

  // Control lines and read data drive
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.t_devsel_n  <= 1'b1;
      bus.t_devsel_oe <= 1'b0;
      bus.t_trdy_n    <= 1'b1;
      bus.t_trdy_oe   <= 1'b0;
      bus.t_ack64_n   <= 1'b1;
      bus.t_ack64_oe  <= 1'b0;
      bus.t_ad        <= {`PWX_ZERO32, `PWX_ZERO32};
      bus.t_ad_oe_lo  <= 1'b0;
      bus.t_ad_oe_hi  <= 1'b0;
      acked           <= 1'b0;
    end else if (st == pwx_t_claim) begin
      bus.t_devsel_n  <= 1'b0;
      bus.t_devsel_oe <= 1'b1;
      // RULE12: ack with devsel
      bus.t_ack64_n   <= !(req_seen && wide_en);
      bus.t_ack64_oe  <= req_seen && wide_en;
      acked           <= req_seen && wide_en;
      bus.t_trdy_oe   <= 1'b1;
    end else if (st == pwx_t_data && bus.t_trdy_n) begin
      bus.t_trdy_n   <= 1'b0;
      bus.t_ad       <= store[idx];
      bus.t_ad_oe_lo <= !is_wr;
      // RULE3: upper read data
      bus.t_ad_oe_hi <= !is_wr && acked;
    end else if (st == pwx_t_data && !bus.irdy_n) begin
      // RULE13: drive high first
      bus.t_devsel_n <= 1'b1;
      bus.t_trdy_n   <= 1'b1;
      bus.t_ack64_n  <= 1'b1;
      bus.t_ad_oe_lo <= 1'b0;
      bus.t_ad_oe_hi <= 1'b0;
    end else if (st == pwx_t_rel) begin
      bus.t_devsel_oe <= 1'b0;
      bus.t_trdy_oe   <= 1'b0;
      bus.t_ack64_oe  <= 1'b0;
    end
  end

  // RULE8: parity one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.t_par64    <= 1'b0;
      bus.t_par64_oe <= 1'b0;
    end else begin
      // RULE6: even over 36
      bus.t_par64    <= ^{bus.t_ad[63:32], bus.cbe[7:4]};
      bus.t_par64_oe <= bus.t_ad_oe_hi;
    end
  end

  // Write data capture per byte lane
  always_ff @(posedge clk) begin
    if (st == pwx_t_data && !bus.trdy_n && !bus.irdy_n && is_wr) begin
      for (int b = 0; b < 8; b++) begin
        if (be_ok[b]) store[idx][8*b +: 8] <= bus.ad[8*b +: 8];
      end
    end
  end

  // Observation strobe for the user side
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_strobe <= 1'b0;
      wr_data   <= {`PWX_ZERO32, `PWX_ZERO32};
      wr_be     <= 8'h00;
      wide_seen <= 1'b0;
    end else begin
      wr_strobe <= st == pwx_t_data && !bus.trdy_n && !bus.irdy_n && is_wr;
      if (st == pwx_t_data && !bus.trdy_n && !bus.irdy_n) begin
        wr_data   <= bus.ad;
        wr_be     <= be_ok;
        wide_seen <= acked;
      end
    end
  end
endmodule : pwx_target

// >>> pwx_bridge.sv
// Device end: wide extension initiator with response buffer
`timescale 1ns/100ps
`include "pwx_defs.svh"
module pwx_bridge
  import pwx_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic        clk,
  input  wire logic        rst,
  pwx_if.init              bus,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_wide,
  input  wire logic [63:0] req_addr,
  input  wire logic [63:0] req_wdata,
  input  wire logic [7:0]  req_be,
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic [63:0]      rsp_data,
  output logic             rsp_wide,
  output logic             rsp_abort,
  output logic             wide_path
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int RW = 66;

  // Pointer step with wrap, used by both buffer ends
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) step = '0;
    else step = p + AW'(1);
  endfunction : step

  pwx_ini_state_t st;         // Transaction sequence
  logic [63:0]    addr;       // Captured address
  logic [3:0]     cmd;        // Captured command
  logic [63:0]    wdata;      // Captured write data
  logic [7:0]     be;         // Captured byte enables, active high
  logic           is_wr;      // Write transaction
  logic           dac;        // Two address phases needed
  logic [2:0]     cnt;        // Cycles waited for a claim
  logic           strap_s1;   // Strap sampler, first stage
  logic           strap_s2;   // Strap sampler, second stage
  logic           accept;     // Request taken this cycle
  logic           go_data;    // Last address phase ends this cycle
  logic           done_ok;    // Data phase completes
  logic           aborted;    // No target claimed in time
  logic           push;       // Buffer write
  logic [RW-1:0]  push_word;  // {abort, wide, data}
  logic [RW-1:0]  buf_mem [DEPTH]; // Response buffer storage
  logic [AW-1:0]  wr_ptr;
  logic [AW-1:0]  rd_ptr;
  logic [AW:0]    count;
  logic           full;
  logic           pop;
  logic           ad_oe_hi;   // Upper lane enable before parking
  logic           cbe_oe_hi;

  // Request is taken only on an idle bus with buffer room, so a
  // stalled reader holds off new transactions instead of losing words
  assign full      = count == (AW+1)'(DEPTH);
  assign req_ready = st == pwx_i_idle && !full && bus.frame_n && bus.irdy_n
                     && bus.devsel_n;
  assign accept    = req_valid && req_ready;
  assign go_data   = (st == pwx_i_addr1 && !dac) || st == pwx_i_addr2;
  assign done_ok   = st == pwx_i_data && !bus.devsel_n && !bus.trdy_n
                     && !bus.i_irdy_n;
  assign aborted   = st == pwx_i_data && bus.devsel_n && cnt == `PWX_ABORT_CYC;
  assign push      = done_ok || aborted;
  // RULE15: upper lanes ignored
  assign push_word = {aborted, !bus.primary_wide_ack_n && !aborted,
                      (is_wr || bus.primary_wide_ack_n) ? `PWX_ZERO32 : bus.ad[63:32],
                      is_wr ? `PWX_ZERO32 : bus.ad[31:0]};

  // RULE11: permanently park upper
  assign bus.i_ad_oe_hi  = ad_oe_hi | ~wide_path;
  assign bus.i_cbe_oe_hi = cbe_oe_hi | ~wide_path;

  // Strap line passes two flops before anything reads it
  always_ff @(posedge clk) begin
    strap_s1 <= bus.primary_wide_request_n;
    strap_s2 <= strap_s1;
  end

  // RULE10: strap sampled in reset
  always_ff @(posedge clk) begin
    if (rst) wide_path <= ~strap_s2;
  end

  // Sequence and request capture
  always_ff @(posedge clk) begin
    if (rst) begin
      st      <= pwx_i_idle;
      addr    <= {`PWX_ZERO32, `PWX_ZERO32};
      cmd     <= `PWX_CMD_MEMRD;
      wdata   <= {`PWX_ZERO32, `PWX_ZERO32};
      be      <= 8'h00;
      is_wr   <= 1'b0;
      dac     <= 1'b0;
      cnt     <= 3'h0;
    end else begin
      case (st)
        pwx_i_idle: begin
          if (accept) begin
            addr    <= req_addr;
            cmd     <= req_write ? `PWX_CMD_MEMWR : `PWX_CMD_MEMRD;
            wdata   <= req_wdata;
            be      <= req_be;
            is_wr   <= req_write;
            // Upper half zero means one address phase suffices
            dac     <= |req_addr[63:32];
            st      <= pwx_i_addr1;
          end
        end
        pwx_i_addr1: st <= dac ? pwx_i_addr2 : pwx_i_data;
        pwx_i_addr2: st <= pwx_i_data;
        pwx_i_data: begin
          cnt <= cnt + 3'h1;
          // Master abort after a fixed wait, so a dead bus cannot hang us
          if (push) begin
            cnt <= 3'h0;
            st  <= pwx_i_done;
          end
        end
        pwx_i_done: st <= pwx_i_idle;
        default:    st <= pwx_i_idle;
      endcase
    end
  end

  // Frame, wide request and ready lines
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.i_frame_n  <= 1'b1;
      bus.i_frame_oe <= 1'b0;
      bus.i_req64_n  <= 1'b1;
      bus.i_req64_oe <= 1'b0;
      bus.i_irdy_n   <= 1'b1;
      bus.i_irdy_oe  <= 1'b0;
    end else if (accept) begin
      bus.i_frame_n  <= 1'b0;
      bus.i_frame_oe <= 1'b1;
      // RULE9: request with frame
      bus.i_req64_n  <= !(req_wide && wide_path);
      bus.i_req64_oe <= req_wide && wide_path;
    end else if (go_data) begin
      // Single data phase: frame and request drop as ready rises
      bus.i_frame_n  <= 1'b1;
      bus.i_req64_n  <= 1'b1;
      bus.i_irdy_n   <= 1'b0;
      bus.i_irdy_oe  <= 1'b1;
    end else if (st == pwx_i_data) begin
      // RULE13: release after high
      bus.i_frame_oe <= 1'b0;
      bus.i_req64_oe <= 1'b0;
      if (push) bus.i_irdy_n <= 1'b1;
    end else if (st == pwx_i_done) begin
      bus.i_irdy_oe <= 1'b0;
    end
  end

  // Address, command and write data lanes
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.i_ad        <= {`PWX_ZERO32, `PWX_ZERO32};
      bus.i_ad_oe_lo  <= 1'b0;
      ad_oe_hi        <= 1'b0;
      bus.i_cbe       <= 8'hFF;
      bus.i_cbe_oe_lo <= 1'b0;
      cbe_oe_hi       <= 1'b0;
    end else if (accept) begin
      // RULE1: upper address out
      // RULE2: valid level anyway
      bus.i_ad        <= req_addr;
      bus.i_ad_oe_lo  <= 1'b1;
      ad_oe_hi        <= 1'b1;
      // RULE4: command on upper
      // RULE14: dual address first
      bus.i_cbe[7:4]  <= req_write ? `PWX_CMD_MEMWR : `PWX_CMD_MEMRD;
      bus.i_cbe[3:0]  <= (|req_addr[63:32]) ? `PWX_CMD_DAC :
                         (req_write ? `PWX_CMD_MEMWR : `PWX_CMD_MEMRD);
      bus.i_cbe_oe_lo <= 1'b1;
      cbe_oe_hi       <= 1'b1;
    end else if (st == pwx_i_addr1 && dac) begin
      // Second phase: upper address low, real command
      bus.i_ad[31:0]  <= addr[63:32];
      bus.i_cbe[3:0]  <= cmd;
    end else if (go_data) begin
      // RULE5: upper byte enables
      bus.i_cbe <= ~be;
      // RULE3: upper write data
      if (is_wr) bus.i_ad <= wdata;
      // Reads turn the lanes around for the target
      bus.i_ad_oe_lo <= is_wr;
      ad_oe_hi       <= is_wr;
    end else if (push) begin
      bus.i_ad_oe_lo  <= 1'b0;
      ad_oe_hi        <= 1'b0;
      bus.i_cbe_oe_lo <= 1'b0;
      cbe_oe_hi       <= 1'b0;
    end
  end

  // RULE7: parity after address
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.i_par64    <= 1'b0;
      // Parked board keeps parity driven through reset too
      bus.i_par64_oe <= ~wide_path;
    end else begin
      // RULE6: even over 36
      bus.i_par64    <= ^{bus.i_ad[63:32], bus.i_cbe[7:4]};
      // RULE8: follows data drive
      bus.i_par64_oe <= bus.i_ad_oe_hi;
    end
  end

  // Response buffer: write side
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (push) begin
      buf_mem[wr_ptr] <= push_word;
      wr_ptr          <= step(wr_ptr);
    end
  end

  // Response buffer: read side and fill level
  assign pop       = rsp_valid && rsp_ready;
  assign rsp_valid = count != '0;
  assign rsp_data  = buf_mem[rd_ptr][63:0];
  assign rsp_wide  = buf_mem[rd_ptr][64];
  assign rsp_abort = buf_mem[rd_ptr][65];
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (pop) rd_ptr <= step(rd_ptr);
      // Push cannot meet a full buffer, room was checked at accept
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pwx_bridge

// >>> pwx_checker.sv
// Checker for the shared wires of the primary bus wide extension
`timescale 1ns/100ps
`include "pwx_defs.svh"
module pwx_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [63:0] ad,
  input wire logic [7:0]  cbe,
  input wire logic        primary_upper_parity,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        devsel_n,
  input wire logic        trdy_n,
  input wire logic        primary_wide_request_n,
  input wire logic        primary_wide_ack_n,
  input wire logic        i_req64_n,
  input wire logic        i_req64_oe,
  input wire logic        i_ad_oe_lo,
  input wire logic        i_ad_oe_hi,
  input wire logic        i_par64_oe,
  input wire logic        t_ad_oe_lo,
  input wire logic        t_ad_oe_hi,
  input wire logic        t_par64_oe,
  input wire logic        t_ack64_n,
  input wire logic        t_ack64_oe
);
  // Single clock domain, so one default clocking and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // First phase of a wide dual-address cycle
  sequence s_dac_first;
    $fell(frame_n) && !primary_wide_request_n && cbe[3:0] == `PWX_CMD_DAC;
  endsequence
  // Second phase: upper halves move down, real command follows
  sequence s_dac_second;
    cbe[3:0] == $past(cbe[7:4]) && ad[31:0] == $past(ad[63:32])
      && (cbe[3:0] == `PWX_CMD_MEMRD || cbe[3:0] == `PWX_CMD_MEMWR);
  endsequence
  // Command and upper address order across both phases
  a_dac_cmd_order: assert property (s_dac_first |=> s_dac_second)
    else $error("dual-address phases carry wrong command or address");
  // Parity one cycle after its lanes, even over 36 bits
  a_upper_parity: assert property (
    (($past(i_ad_oe_hi) && !($past(frame_n) && $past(irdy_n)) && i_par64_oe)
      || ($past(t_ad_oe_hi) && t_par64_oe))
    |-> primary_upper_parity == ^{$past(ad[63:32]), $past(cbe[7:4])})
    else $error("upper parity mismatch");
  // Request only inside frame, and gone when frame ends
  a_req_with_frame: assert property ((i_req64_oe && !i_req64_n) |-> !frame_n)
    else $error("wide request outside frame");
  a_req_ends_frame: assert property ($rose(frame_n) |-> primary_wide_request_n)
    else $error("wide request outlives frame");
  // Acknowledge starts with claim, only after a request
  a_ack_after_req: assert property ($fell(primary_wide_ack_n) |-> $fell(devsel_n)
    && (!$past(primary_wide_request_n) || !$past(primary_wide_request_n, 2)))
    else $error("wide ack without request or claim");
  a_ack_ends_claim: assert property ($rose(devsel_n) |-> primary_wide_ack_n)
    else $error("wide ack outlives claim");
  // Released lines are driven high for exactly one cycle first
  a_req_release: assert property ($fell(i_req64_oe)
    |-> $past(i_req64_n) && !$past(i_req64_n, 2))
    else $error("wide request released without one high cycle");
  a_ack_release: assert property ($rose(primary_wide_ack_n)
    |-> t_ack64_oe ##1 !t_ack64_oe)
    else $error("wide ack released without one high cycle");
  // Upper lanes follow the acknowledge in data phases
  a_wide_read_lanes: assert property (
    (!trdy_n && t_ad_oe_lo && !primary_wide_ack_n) |-> t_ad_oe_hi)
    else $error("wide read without upper data");
  a_narrow_read_lanes: assert property (
    (!trdy_n && t_ad_oe_lo && primary_wide_ack_n) |-> !t_ad_oe_hi)
    else $error("narrow read drives upper lanes");
  a_wide_write_lanes: assert property (
    (!irdy_n && i_ad_oe_lo && !primary_wide_ack_n) |-> i_ad_oe_hi)
    else $error("wide write without upper data");
endmodule : pwx_checker

// >>> primary_bus_wide_extension_tb.sv
// Bench joining the wide extension initiator and target on one bus
`timescale 1ns/100ps
module primary_bus_wide_extension_tb;
  logic        clk        = 1'b0;  // 25 MHz bus clock
  logic        rst        = 1'b1;  // Synchronous reset, high
  logic        req_valid  = 1'b0;  // User request side
  logic        req_write  = 1'b0;
  logic        req_wide   = 1'b0;
  logic [63:0] req_addr   = 64'h0;
  logic [63:0] req_wdata  = 64'h0;
  logic [7:0]  req_be     = 8'h00;
  logic        rsp_ready  = 1'b0;
  logic        wide_en    = 1'b0;  // Target may take wide phases
  logic        stall      = 1'b0;  // Holds the response taker off
  logic        strap_wide = 1'b1;  // Strap the bench applied
  logic        req_ready, rsp_valid, rsp_wide, rsp_abort, wide_path, wr_strobe, wide_seen;
  logic [63:0] rsp_data, wr_data;
  logic [7:0]  wr_be;
  logic [63:0] rq_d[$], wq_d[$];   // Expected answers and writes, in order
  logic        rq_w[$], wq_w[$];
  logic [7:0]  wq_b[$];
  int          error_cnt  = 0;
  int          num_checks = 0;
  always #20 clk = ~clk;
  pwx_if bus_if ();
  pwx_bridge pwx_bridge_i (.clk(clk), .rst(rst), .bus(bus_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_wide(req_wide), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .rsp_wide(rsp_wide), .rsp_abort(rsp_abort), .wide_path(wide_path));
  pwx_target pwx_target_i (.clk(clk), .rst(rst), .bus(bus_if), .wide_en(wide_en),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .wr_be(wr_be), .wide_seen(wide_seen));
  pwx_checker pwx_checker_i (.clk(clk), .rst(rst), .ad(bus_if.ad), .cbe(bus_if.cbe),
    .primary_upper_parity(bus_if.primary_upper_parity), .frame_n(bus_if.frame_n),
    .irdy_n(bus_if.irdy_n), .devsel_n(bus_if.devsel_n), .trdy_n(bus_if.trdy_n),
    .primary_wide_request_n(bus_if.primary_wide_request_n),
    .primary_wide_ack_n(bus_if.primary_wide_ack_n), .i_req64_n(bus_if.i_req64_n),
    .i_req64_oe(bus_if.i_req64_oe), .i_ad_oe_lo(bus_if.i_ad_oe_lo),
    .i_ad_oe_hi(bus_if.i_ad_oe_hi), .i_par64_oe(bus_if.i_par64_oe),
    .t_ad_oe_lo(bus_if.t_ad_oe_lo), .t_ad_oe_hi(bus_if.t_ad_oe_hi),
    .t_par64_oe(bus_if.t_par64_oe), .t_ack64_n(bus_if.t_ack64_n),
    .t_ack64_oe(bus_if.t_ack64_oe));
  // Random taker stalls; a full stall lets the buffer fill
  always @(posedge clk) rsp_ready <= stall ? 1'b0 : ($urandom_range(3) != 0);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // A bound ran out: count it and stop
  task automatic bail();
    error_cnt++;
    finish_test();
  endtask : bail
  // Lanes that carry data: upper half only when the wide phase was agreed
  function automatic logic [63:0] lane_mask(input logic ok);
    return ok ? 64'hFFFFFFFFFFFFFFFF : 64'h00000000FFFFFFFF;
  endfunction : lane_mask
  task automatic end_test(input string s);
    $display("test %s done, checks=%0d mismatches=%0d", s, num_checks, error_cnt);
  endtask : end_test
  // Strap is held through reset, then left to the pull-up
  task automatic run_reset(input logic wide);
    strap_wide = wide;
    @(posedge clk);
    rst <= 1'b1;
    bus_if.board_req64_n <= !wide;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus_if.board_req64_n <= 1'b1;
  endtask : run_reset
  task automatic drain();
    int n;
    n = 0;
    while (rq_d.size() != 0 || wq_d.size() != 0) begin
      n++;
      if (n > 300) bail();
      @(negedge clk);
    end
    repeat (2) @(posedge clk);
  endtask : drain
  // One user request, held until taken; expectations queued after
  task automatic do_req(input logic w, input logic wd, input logic [63:0] a,
                        input logic [63:0] d, input logic [7:0] b);
    logic ok;
    int   n;
    n = 0;
    @(posedge clk);
    ok = wd & wide_en & strap_wide;
    req_valid <= 1'b1;
    req_write <= w;
    req_wide  <= wd;
    req_addr  <= a;
    req_wdata <= d;
    req_be    <= b;
    @(negedge clk);
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 200) bail();
      @(negedge clk);
    end
    @(posedge clk);
    req_valid <= 1'b0;
    rq_d.push_back(w ? 64'h0 : d & lane_mask(ok));
    rq_w.push_back(ok);
    if (w) begin
      wq_d.push_back(d);
      wq_w.push_back(ok);
      wq_b.push_back(b);
    end
  endtask : do_req
  // Write, read back, then a write with random enables; modes rotate
  task automatic run_pairs(input int cnt);
    logic [63:0] a;
    logic [63:0] d;
    for (int i = 0; i < cnt; i++) begin
      drain();
      wide_en <= (i % 3) != 0;
      a = {(i % 2) ? $urandom() : 32'h0, $urandom()};
      a[2:0] = 3'h0;
      if (i == 1) a[63:32] = 32'hFFFFFFFF;
      d = {$urandom(), $urandom()};
      do_req(1'b1, i[1], a, d, 8'hFF);
      do_req(1'b0, i[1], a, d, 8'hFF);
      do_req(1'b1, i[1], a, ~d, 8'($urandom()));
    end
  endtask : run_pairs
  // Each answer as it is taken, each completed write at the target
  always @(negedge clk) begin
    if (!rst && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      chk(64'(rq_d.size() != 0), 64'h1);
      if (rq_d.size() != 0) begin
        chk(rsp_data, rq_d.pop_front());
        chk({rsp_abort, rsp_wide}, {1'b0, rq_w.pop_front()});
      end
    end
    if (!rst && wr_strobe === 1'b1) begin
      chk(64'(wq_d.size() != 0), 64'h1);
      if (wq_d.size() != 0) begin
        chk(wr_data & lane_mask(wq_w[0]), wq_d[0] & lane_mask(wq_w[0]));
        chk(wr_be & 8'(lane_mask(wq_w[0]) >> 28), wq_b[0] & 8'(lane_mask(wq_w[0]) >> 28));
        chk(wide_seen, wq_w.pop_front());
        void'(wq_d.pop_front());
        void'(wq_b.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(71163));
    bus_if.board_req64_n = 1'b0;
    run_reset(1'b1);
    chk(wide_path, 1'b1);
    end_test("strap_low");
    run_pairs(12);
    end_test("wide_pairs");
    // Taker held off: two answers fill the buffer and requests are refused
    drain();
    stall <= 1'b1;
    do_req(1'b1, 1'b1, 64'h40, 64'h0123456789ABCDEF, 8'hFF);
    do_req(1'b1, 1'b0, 64'h48, 64'hFEDCBA9876543210, 8'h0F);
    repeat (12) @(negedge clk);
    repeat (4) begin
      @(negedge clk);
      chk(req_ready, 1'b0);
    end
    stall <= 1'b0;
    do_req(1'b0, 1'b1, 64'h40, 64'h0123456789ABCDEF, 8'hFF);
    drain();
    end_test("buffer_full");
    // Narrow board: upper lanes stay parked and nothing goes wide
    run_reset(1'b0);
    chk(wide_path, 1'b0);
    repeat (3) begin
      @(negedge clk);
      chk({bus_if.i_ad_oe_hi, bus_if.i_cbe_oe_hi, bus_if.i_par64_oe}, 3'h7);
    end
    run_pairs(6);
    drain();
    end_test("strap_high");
    finish_test();
  end
endmodule : primary_bus_wide_extension_tb
